// ===== pkg/tscfg_pkg.sv
package tscfg_pkg;

    // ************************************************************
    // Register pointer values
    // ************************************************************
    localparam logic [7:0] TSCFG_ADDR_CFG   = 8'h01;
    localparam logic [7:0] TSCFG_ADDR_UPPER = 8'h02;
    localparam logic [7:0] TSCFG_ADDR_LOWER = 8'h03;
    localparam logic [7:0] TSCFG_ADDR_CRIT  = 8'h04;
    localparam logic [7:0] TSCFG_ADDR_TEMP  = 8'h05;
    localparam logic [7:0] TSCFG_PTR_RST    = 8'h00;

    // ************************************************************
    // Configuration register field positions
    // ************************************************************
    localparam int TSCFG_HYS_MSB       = 10;
    localparam int TSCFG_HYS_LSB       = 9;
    localparam int TSCFG_BIT_PD        = 8;
    localparam int TSCFG_BIT_CRIT_LOCK = 7;
    localparam int TSCFG_BIT_WIN_LOCK  = 6;
    localparam int TSCFG_BIT_RELEASE   = 5;
    localparam int TSCFG_BIT_STATUS    = 4;
    localparam int TSCFG_BIT_OE        = 3;
    localparam int TSCFG_BIT_CRIT_ONLY = 2;
    localparam int TSCFG_BIT_POL       = 1;
    localparam int TSCFG_BIT_LATCH     = 0;

    // ************************************************************
    // Limit and temperature layouts
    // ************************************************************
    localparam int TSCFG_LIM_MSB  = 12;
    localparam int TSCFG_LIM_LSB  = 2;
    localparam int TSCFG_TEMP_MSB = 12;

    localparam logic [15:0] TSCFG_CFG_RST  = 16'h0000;
    localparam logic [15:0] TSCFG_WORD_ZERO = 16'h0000;
    localparam logic [10:0] TSCFG_LIM_RST  = 11'h000;
    localparam logic [12:0] TSCFG_TEMP_RST = 13'h0000;
    localparam logic [1:0]  TSCFG_LIM_PAD  = 2'h0;

    // ************************************************************
    // Hysteresis codes and amounts in 0.0625 degree steps
    // ************************************************************
    typedef enum logic [1:0] {
        TSCFG_HYS_OFF = 2'h0,
        TSCFG_HYS_1P5 = 2'h1,
        TSCFG_HYS_3P0 = 2'h2,
        TSCFG_HYS_6P0 = 2'h3
    } tscfg_hys_t;

    localparam logic [13:0] TSCFG_HYS_AMT_OFF = 14'h0000;
    localparam logic [13:0] TSCFG_HYS_AMT_1P5 = 14'h0018;
    localparam logic [13:0] TSCFG_HYS_AMT_3P0 = 14'h0030;
    localparam logic [13:0] TSCFG_HYS_AMT_6P0 = 14'h0060;

    // The alert pin is open drain: it only ever pulls low.
    localparam logic TSCFG_PIN_LOW = 1'b0;

endpackage

// ===== pkg/tscfg_alert_if.sv
`timescale 1ns/10ps
interface tscfg_alert_if;
    logic limit_cond;
    logic sample_p;
    logic power_down;
    logic out_en;
    logic polarity;
    logic latch_sel;
    logic release_p;
    logic asserted;
    logic pin_oe;

    modport ctl (
        output limit_cond,
        output sample_p,
        output power_down,
        output out_en,
        output polarity,
        output latch_sel,
        output release_p,
        input  asserted,
        input  pin_oe
    );

    modport drv (
        input  limit_cond,
        input  sample_p,
        input  power_down,
        input  out_en,
        input  polarity,
        input  latch_sel,
        input  release_p,
        output asserted,
        output pin_oe
    );
endinterface

// ===== core/tscfg_alert.sv
`timescale 1ns/10ps
module tscfg_alert (
    // Clock and synchronised reset
    input wire logic     clk,
    input wire logic     rst_n,
    // Configuration and condition from the register bank
    tscfg_alert_if.drv   al
);
    import tscfg_pkg::*;

    typedef struct packed {
        logic latch;
        logic prev_cond;
        logic asserted;
        logic pin_oe;
    } tscfg_alert_st_t;

    tscfg_alert_st_t st_r;
    tscfg_alert_st_t st_nxt;
    logic            active;

    // ************************************************************
    // Alert latch and pin drive
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        if (al.release_p) begin
            st_nxt.latch = 1'b0;
        end
        // A new crossing in the same cycle as a release keeps the latch set.
        if (al.sample_p && al.limit_cond && !st_r.prev_cond && al.out_en && !al.power_down) begin
            st_nxt.latch = 1'b1;
        end
        if (!al.latch_sel) begin
            st_nxt.latch = 1'b0;
        end
        if (al.sample_p) begin
            st_nxt.prev_cond = al.limit_cond;
        end
        // Comparator mode follows the frozen condition during power down.
        active = al.latch_sel ? st_nxt.latch : al.limit_cond;
        st_nxt.asserted = al.out_en & active;
        st_nxt.pin_oe = al.polarity ? ~st_nxt.asserted : st_nxt.asserted;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign al.asserted = st_r.asserted;
    assign al.pin_oe   = st_r.pin_oe;

endmodule

// ===== core/tscfg_top.sv
`timescale 1ns/10ps
// What this block does
// - Configuration register at pointer 01h, read/write.
// - Hysteresis code selects 0, 1.5, 3, 6 degrees.
// - Hysteresis applies only to falling temperature.
// - Upper and critical conditions hold until below limit minus hysteresis.
// - Hysteresis writes ignored while any lock set.
// - Power-down bit stops continuous conversion.
// - Power down freezes temperature, no new interrupts.
// - Power-down set refused when locked; clear allowed.
// - Bus access and timeout stay active in power down.
// - Critical lock blocks critical limit updates.
// - Window lock blocks upper and lower limits.
// - Lock bits sticky until power-on reset.
// - Release bit frees latched alert; reads zero.
// - Status bit shows alert asserted.
// - Enable bit gates alert output and interrupts.
// - Enable writes ignored while any lock set.
// - Critical-only bit restricts alert to critical.
// - Critical-only writes ignored under window lock.
// - Polarity bit selects alert active level.
// - Mode bit selects comparator or latched alert.
// - Polarity and mode ignored while any lock set.
// - Pointer write selects register for access.
// - Writes to read-only or locked registers ignored.
// - Window lock makes window limits read-only.
// - Critical lock makes critical limit read-only.
module tscfg_top (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Register access from the serial bus engine
    input  wire logic        ptr_wr,
    input  wire logic [7:0]  ptr_data,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // Conversion engine
    input  wire logic [12:0] temp_sample,
    input  wire logic        temp_sample_valid,
    output logic             convert_enable,
    output logic             bus_timeout_enable,
    // Alert pin, open drain
    output logic             alert_pin_o,
    output logic             alert_pin_oe
);
    import tscfg_pkg::*;

    typedef struct packed {
        logic [7:0]  ptr;
        tscfg_hys_t  hysteresis_field;
        logic        power_down;
        logic        crit_lock;
        logic        win_lock;
        logic        out_en;
        logic        crit_only;
        logic        polarity;
        logic        latch_sel;
        logic [10:0] upper;
        logic [10:0] lower;
        logic [10:0] crit;
        logic [12:0] temp;
        logic        upper_hi;
        logic        lower_lo;
        logic        crit_hi;
        logic        sample_p;
        logic        release_p;
        logic        conv_en;
        logic [15:0] rdata;
    } tscfg_st_t;

    tscfg_st_t       st_r;
    tscfg_st_t       st_nxt;
    logic [1:0]      rst_sync_r;
    logic            rst_n;
    logic            any_lock;
    logic [13:0]     hys_amt;
    logic [13:0]     t_ext;
    logic [13:0]     up_ext;
    logic [13:0]     lo_ext;
    logic [13:0]     cr_ext;
    logic [15:0]     cfg_word;
    logic            limit_cond;
    tscfg_alert_if   al ();

    // ************************************************************
    // Reset release
    // ************************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [13:0] lim_ext(input logic [10:0] lim);
        logic [12:0] full;
        full = {lim, TSCFG_LIM_PAD};
        return {full[TSCFG_LIM_MSB], full};
    endfunction

    // Signed less-than on 14-bit two's complement values.
    function automatic logic s_lt(input logic [13:0] a, input logic [13:0] b);
        return $signed(a) < $signed(b);
    endfunction

    always_comb begin
        case (st_r.hysteresis_field)
            TSCFG_HYS_1P5: hys_amt = TSCFG_HYS_AMT_1P5;
            TSCFG_HYS_3P0: hys_amt = TSCFG_HYS_AMT_3P0;
            TSCFG_HYS_6P0: hys_amt = TSCFG_HYS_AMT_6P0;
            default:       hys_amt = TSCFG_HYS_AMT_OFF;
        endcase
    end

    assign any_lock = st_r.crit_lock | st_r.win_lock;
    assign t_ext    = {temp_sample[TSCFG_TEMP_MSB], temp_sample};
    assign up_ext   = lim_ext(st_r.upper);
    assign lo_ext   = lim_ext(st_r.lower);
    assign cr_ext   = lim_ext(st_r.crit);

    // ************************************************************
    // Configuration read image
    // ************************************************************
    always_comb begin
        cfg_word = TSCFG_CFG_RST;
        cfg_word[TSCFG_HYS_MSB:TSCFG_HYS_LSB] = st_r.hysteresis_field;
        cfg_word[TSCFG_BIT_PD]        = st_r.power_down;
        cfg_word[TSCFG_BIT_CRIT_LOCK] = st_r.crit_lock;
        cfg_word[TSCFG_BIT_WIN_LOCK]  = st_r.win_lock;
        cfg_word[TSCFG_BIT_STATUS]    = al.asserted;
        cfg_word[TSCFG_BIT_OE]        = st_r.out_en;
        cfg_word[TSCFG_BIT_CRIT_ONLY] = st_r.crit_only;
        cfg_word[TSCFG_BIT_POL]       = st_r.polarity;
        cfg_word[TSCFG_BIT_LATCH]     = st_r.latch_sel;
    end

    // ************************************************************
    // Register bank and limit tracking
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.release_p = 1'b0;
        st_nxt.sample_p  = 1'b0;

        // Bus access is never gated by power down.
        if (ptr_wr) begin
            st_nxt.ptr = ptr_data;
        end

        if (reg_wr) begin
            case (st_r.ptr)
                TSCFG_ADDR_CFG: begin
                    // Locks are judged on their value before this write, so one
                    // write may set a lock and the last free fields together.
                    if (!any_lock) begin
                        st_nxt.hysteresis_field       = tscfg_hys_t'(reg_wdata[TSCFG_HYS_MSB:TSCFG_HYS_LSB]);
                        st_nxt.out_en    = reg_wdata[TSCFG_BIT_OE];
                        st_nxt.polarity  = reg_wdata[TSCFG_BIT_POL];
                        st_nxt.latch_sel = reg_wdata[TSCFG_BIT_LATCH];
                    end
                    if (!st_r.win_lock) begin
                        st_nxt.crit_only = reg_wdata[TSCFG_BIT_CRIT_ONLY];
                    end
                    if (!reg_wdata[TSCFG_BIT_PD]) begin
                        st_nxt.power_down = 1'b0;
                    end else if (!any_lock) begin
                        st_nxt.power_down = 1'b1;
                    end
                    st_nxt.crit_lock = st_r.crit_lock | reg_wdata[TSCFG_BIT_CRIT_LOCK];
                    st_nxt.win_lock  = st_r.win_lock | reg_wdata[TSCFG_BIT_WIN_LOCK];
                    if (reg_wdata[TSCFG_BIT_RELEASE] && st_r.latch_sel) begin
                        st_nxt.release_p = 1'b1;
                    end
                end
                TSCFG_ADDR_UPPER: begin
                    if (!st_r.win_lock) begin
                        st_nxt.upper = reg_wdata[TSCFG_LIM_MSB:TSCFG_LIM_LSB];
                    end
                end
                TSCFG_ADDR_LOWER: begin
                    if (!st_r.win_lock) begin
                        st_nxt.lower = reg_wdata[TSCFG_LIM_MSB:TSCFG_LIM_LSB];
                    end
                end
                TSCFG_ADDR_CRIT: begin
                    if (!st_r.crit_lock) begin
                        st_nxt.crit = reg_wdata[TSCFG_LIM_MSB:TSCFG_LIM_LSB];
                    end
                end
                default: begin
                    // Read-only and unmapped pointers take the write and keep their contents.
                end
            endcase
        end

        // A sample that arrives during power down is dropped whole.
        if (temp_sample_valid && !st_r.power_down) begin
            st_nxt.temp     = temp_sample;
            st_nxt.sample_p = 1'b1;
            if (s_lt(up_ext, t_ext)) begin
                st_nxt.upper_hi = 1'b1;
            end else if (s_lt(t_ext, 14'(up_ext - hys_amt))) begin
                st_nxt.upper_hi = 1'b0;
            end
            if (s_lt(cr_ext, t_ext)) begin
                st_nxt.crit_hi = 1'b1;
            end else if (s_lt(t_ext, 14'(cr_ext - hys_amt))) begin
                st_nxt.crit_hi = 1'b0;
            end
            if (s_lt(t_ext, 14'(lo_ext - hys_amt))) begin
                st_nxt.lower_lo = 1'b1;
            end else if (!s_lt(t_ext, lo_ext)) begin
                st_nxt.lower_lo = 1'b0;
            end
        end

        st_nxt.conv_en = ~st_nxt.power_down;

        case (st_r.ptr)
            TSCFG_ADDR_CFG:   st_nxt.rdata = cfg_word;
            TSCFG_ADDR_UPPER: st_nxt.rdata = 16'({st_r.upper, TSCFG_LIM_PAD});
            TSCFG_ADDR_LOWER: st_nxt.rdata = 16'({st_r.lower, TSCFG_LIM_PAD});
            TSCFG_ADDR_CRIT:  st_nxt.rdata = 16'({st_r.crit, TSCFG_LIM_PAD});
            TSCFG_ADDR_TEMP:  st_nxt.rdata = 16'(st_r.temp);
            default:          st_nxt.rdata = TSCFG_WORD_ZERO;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r          <= '0;
            st_r.ptr      <= TSCFG_PTR_RST;
            st_r.hysteresis_field      <= TSCFG_HYS_OFF;
            st_r.upper    <= TSCFG_LIM_RST;
            st_r.lower    <= TSCFG_LIM_RST;
            st_r.crit     <= TSCFG_LIM_RST;
            st_r.temp     <= TSCFG_TEMP_RST;
            st_r.conv_en  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Alert stage
    // ************************************************************
    assign limit_cond = st_r.crit_only ? st_r.crit_hi
                                       : (st_r.upper_hi | st_r.lower_lo | st_r.crit_hi);

    assign al.limit_cond = limit_cond;
    assign al.sample_p   = st_r.sample_p;
    assign al.power_down = st_r.power_down;
    assign al.out_en     = st_r.out_en;
    assign al.polarity   = st_r.polarity;
    assign al.latch_sel  = st_r.latch_sel;
    assign al.release_p  = st_r.release_p;

    tscfg_alert u_alert (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .al    (al.drv)
    );

    assign reg_rdata          = st_r.rdata;
    assign convert_enable     = st_r.conv_en;
    assign bus_timeout_enable = rst_n;
    assign alert_pin_o        = TSCFG_PIN_LOW;
    assign alert_pin_oe       = al.pin_oe;

endmodule

// ===== testbench/tscfg_properties.sv
`timescale 1ns/10ps
module tscfg_properties (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        resetn,
    // Register access
    input wire logic        ptr_wr,
    input wire logic [7:0]  ptr_data,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    // Conversion and alert
    input wire logic [12:0] temp_sample,
    input wire logic        temp_sample_valid,
    input wire logic        convert_enable,
    input wire logic        bus_timeout_enable,
    input wire logic        alert_pin_o,
    input wire logic        alert_pin_oe
);
    import tscfg_pkg::*;

    // ************************************************************
    // Mirror of the writable configuration fields
    // ************************************************************
    logic [1:0]  sync_r;
    logic [7:0]  ptr_r;
    logic [10:0] cfg_r;
    logic        live;
    logic        lk;
    logic        cw;

    assign live = sync_r[1];
    assign lk   = cfg_r[7] | cfg_r[6];
    assign cw   = reg_wr && ptr_r == TSCFG_ADDR_CFG;

    // Locks are judged on the value before the write, so a locking write lands whole.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync_r <= 2'h0;
            ptr_r  <= TSCFG_PTR_RST;
            cfg_r  <= 11'h000;
        end else begin
            sync_r <= {sync_r[0], 1'b1};
            if (ptr_wr) ptr_r <= ptr_data;
            if (cw) begin
                cfg_r[7:6] <= cfg_r[7:6] | reg_wdata[7:6];
                if (!lk) {cfg_r[10:9], cfg_r[3], cfg_r[1:0]} <= {reg_wdata[10:9], reg_wdata[3], reg_wdata[1:0]};
                if (!cfg_r[6]) cfg_r[2] <= reg_wdata[2];
                if (!reg_wdata[8] || !lk) cfg_r[8] <= reg_wdata[8];
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!live);

    // A configuration write followed by two quiet cycles, so the read image has settled.
    sequence cfg_seq;
        cw && !ptr_wr ##1 (!reg_wr && !ptr_wr) [*2];
    endsequence

    a_pin_opendrain: assert property (alert_pin_o == TSCFG_PIN_LOW)
        else $error("alert pin driven to the high level");
    a_timeout_live: assert property ($past(live, 2) |-> bus_timeout_enable)
        else $error("bus timeout disabled out of reset");
    a_reserved_zero: assert property (cfg_seq |=> reg_rdata[15:11] == 5'h00 && !reg_rdata[5])
        else $error("reserved or release bit reads nonzero");
    a_hys_guard: assert property (cfg_seq |=> reg_rdata[10:9] == cfg_r[10:9])
        else $error("hysteresis field wrong after write");
    a_pd_guard: assert property (cfg_seq |=> reg_rdata[8] == cfg_r[8] && convert_enable == !cfg_r[8])
        else $error("power down bit or conversion enable wrong");
    a_lock_sticky: assert property (cfg_seq |=> reg_rdata[7:6] == cfg_r[7:6])
        else $error("lock bits wrong after write");
    a_enable_guard: assert property (cfg_seq |=> reg_rdata[3] == cfg_r[3])
        else $error("alert enable wrong after write");
    a_crit_only: assert property (cfg_seq |=> reg_rdata[2] == cfg_r[2])
        else $error("critical only bit wrong after write");
    a_pol_mode: assert property (cfg_seq |=> reg_rdata[1:0] == cfg_r[1:0])
        else $error("polarity or mode wrong after write");
    a_alert_off: assert property (cfg_seq ##1 !cfg_r[3] && !cfg_r[8] |-> alert_pin_oe == cfg_r[1] && !reg_rdata[4])
        else $error("disabled alert still asserted");

    c_locked_write: cover property (cw && lk);
    c_alert_on: cover property ($rose(alert_pin_oe));
    c_power_down: cover property (!convert_enable);
endmodule

bind tscfg_top tscfg_properties u_tscfg_properties (.ref_clk, .resetn, .ptr_wr, .ptr_data, .reg_wr, .reg_wdata,
    .reg_rdata, .temp_sample, .temp_sample_valid, .convert_enable, .bus_timeout_enable, .alert_pin_o, .alert_pin_oe);

// ===== testbench/tscfg_host_model.sv
`timescale 1ns/10ps
module tscfg_host_model (
    // Clock
    input  wire logic        clk,
    // Register access towards the device
    output logic             ptr_wr,
    output logic [7:0]       ptr_data,
    output logic             reg_wr,
    output logic [15:0]      reg_wdata
);
    initial begin
        ptr_wr    = 1'b0;
        ptr_data  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 16'h0000;
    end

    // Released lines carry the inverse of their last value, so stale data never passes for a request.
    task automatic point(input logic [7:0] a);
        @(posedge clk);
        ptr_wr   <= 1'b1;
        ptr_data <= a;
        @(posedge clk);
        ptr_wr   <= 1'b0;
        ptr_data <= ~a;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        point(a);
        reg_wr    <= 1'b1;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
        repeat (2) @(posedge clk);
    endtask
endmodule

// ===== testbench/tscfg_top_tb.sv
`timescale 1ns/10ps
module tscfg_top_tb;
    import tscfg_pkg::*;
    localparam logic [7:0] CFG = TSCFG_ADDR_CFG;
    logic        ref_clk, resetn, ptr_wr, reg_wr, temp_sample_valid, pin;
    logic [7:0]  ptr_data;
    logic [15:0] reg_wdata, reg_rdata;
    logic [12:0] temp_sample;
    logic        convert_enable, bus_timeout_enable, alert_pin_o, alert_pin_oe;
    int          error_cnt, comparisons;

    // The alert line has a pull-up, so a released pin reads high.
    assign pin = alert_pin_oe ? alert_pin_o : 1'b1;

    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;

    tscfg_top u_tscfg_top (.ref_clk, .resetn, .ptr_wr, .ptr_data, .reg_wr, .reg_wdata, .reg_rdata, .temp_sample,
        .temp_sample_valid, .convert_enable, .bus_timeout_enable, .alert_pin_o, .alert_pin_oe);
    tscfg_host_model u_tscfg_host_model (.clk(ref_clk), .ptr_wr, .ptr_data, .reg_wr, .reg_wdata);

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chb(input string n, input logic e, input logic g);
        chk(n, {15'h0, e}, {15'h0, g});
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_tscfg_host_model.wr_reg(a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        u_tscfg_host_model.point(a);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("reg_rdata", e, reg_rdata);
    endtask
    task automatic smp(input logic [12:0] t);
        @(posedge ref_clk);
        temp_sample       <= t;
        temp_sample_valid <= 1'b1;
        @(posedge ref_clk);
        temp_sample_valid <= 1'b0;
        temp_sample       <= ~t;
        repeat (3) @(posedge ref_clk);
    endtask
    // Checks the pin level and the status bit against an expected asserted state.
    task automatic ev(input logic [15:0] c, input logic a);
        @(posedge ref_clk);
        #1;
        chb("alert pin", c[1] ? a : !a, pin);
        rd(CFG, c | {11'h0, a, 4'h0});
    endtask
    task automatic rst;
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic t_reset;
        rst();
        #1;
        chb("convert_enable", 1'b1, convert_enable);
        chb("bus_timeout_enable", 1'b1, bus_timeout_enable);
        chb("alert pin", 1'b1, pin);
        rd(CFG, TSCFG_CFG_RST);
        rd(8'h08, 16'h0000);
        $display("t_reset done");
    endtask
    task automatic t_cfg;
        for (int h = 0; h < 4; h++) begin
            wr(CFG, {5'h0, h[1:0], 9'h0});
            rd(CFG, {5'h0, h[1:0], 9'h0});
        end
        wr(CFG, 16'hFF3F);
        rd(CFG, 16'h070F);
        chb("convert_enable", 1'b0, convert_enable);
        chb("bus_timeout_enable", 1'b1, bus_timeout_enable);
        wr(CFG, 16'h0000);
        rd(CFG, 16'h0000);
        $display("t_cfg done");
    endtask
    task automatic t_compare;
        wr(TSCFG_ADDR_CRIT, 16'h0400);
        wr(TSCFG_ADDR_UPPER, 16'h00A0);
        wr(CFG, 16'h0208);
        smp(13'h0A1);
        ev(16'h0208, 1'b1);
        smp(13'h089);
        ev(16'h0208, 1'b1);
        smp(13'h087);
        ev(16'h0208, 1'b0);
        smp(13'h0A0);
        ev(16'h0208, 1'b0);
        smp(13'h0A1);
        wr(CFG, 16'h020A);
        ev(16'h020A, 1'b1);
        wr(CFG, 16'h020C);
        ev(16'h020C, 1'b0);
        smp(13'h0401);
        ev(16'h020C, 1'b1);
        wr(CFG, 16'h0200);
        ev(16'h0200, 1'b0);
        $display("t_compare done");
    endtask
    task automatic t_latched;
        smp(13'h050);
        wr(CFG, 16'h0209);
        smp(13'h0A1);
        ev(16'h0209, 1'b1);
        smp(13'h050);
        ev(16'h0209, 1'b1);
        wr(CFG, 16'h0229);
        ev(16'h0209, 1'b0);
        wr(CFG, 16'h0208);
        smp(13'h0A1);
        wr(CFG, 16'h0228);
        ev(16'h0208, 1'b1);
        $display("t_latched done");
    endtask
    task automatic t_pdown;
        wr(CFG, 16'h0308);
        smp(13'h050);
        rd(TSCFG_ADDR_TEMP, 16'h00A1);
        chb("convert_enable", 1'b0, convert_enable);
        ev(16'h0308, 1'b1);
        wr(TSCFG_ADDR_LOWER, 16'h0080);
        wr(CFG, 16'h0208);
        smp(13'h067);
        ev(16'h0208, 1'b1);
        smp(13'h080);
        ev(16'h0208, 1'b0);
        wr(CFG, 16'h0000);
        $display("t_pdown done");
    endtask
    task automatic t_locks;
        wr(CFG, 16'h0040);
        rd(CFG, 16'h0040);
        wr(TSCFG_ADDR_UPPER, 16'h0123);
        rd(TSCFG_ADDR_UPPER, 16'h00A0);
        wr(TSCFG_ADDR_LOWER, 16'h0123);
        rd(TSCFG_ADDR_LOWER, 16'h0080);
        wr(CFG, 16'hFFBF);
        rd(CFG, 16'h00C0);
        wr(TSCFG_ADDR_CRIT, 16'h0300);
        rd(TSCFG_ADDR_CRIT, 16'h0400);
        wr(CFG, 16'h0000);
        rd(CFG, 16'h00C0);
        rst();
        wr(CFG, 16'h0100);
        wr(CFG, 16'h0180);
        wr(CFG, 16'h018C);
        rd(CFG, 16'h0184);
        wr(CFG, 16'h0000);
        rd(CFG, 16'h0080);
        wr(CFG, 16'h0100);
        rd(CFG, 16'h0080);
        wr(TSCFG_ADDR_UPPER, 16'h0300);
        rd(TSCFG_ADDR_UPPER, 16'h0300);
        $display("t_locks done");
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        error_cnt         = 0;
        comparisons       = 0;
        resetn            = 1'b0;
        temp_sample       = 13'h0000;
        temp_sample_valid = 1'b0;
        t_reset();
        t_cfg();
        t_compare();
        t_latched();
        t_pdown();
        t_locks();
        tally_and_finish();
    end
    initial begin
        #1000000;
        error_cnt++;
        $display("ERROR watchdog expired");
        tally_and_finish();
    end
endmodule
